// ==== shared/fsk_dev_pkg.sv ====
// Constants and types shared by the FSK deviation select logic
package fsk_dev_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MODE    = 8'h04;
  localparam logic [7:0] ADDR_DEVSEL  = 8'h08;
  localparam logic [7:0] ADDR_DIRECT  = 8'h0c;
  localparam logic [7:0] ADDR_NUMBASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [7:0] ADDR_TABLE   = 8'h40;
  localparam logic [7:0] ADDR_TABLE_END = 8'h7c;
  // Field positions
  localparam int CAL_BIT      = 0;
  localparam int SET_BIT      = 6;
  localparam int MODE_LO_BIT  = 0;
  localparam int MODE_HI_BIT  = 1;
  localparam int LVL_LSB      = 2;
  localparam int EN1_BIT      = 5;
  localparam int EN2_BIT      = 6;
  localparam int ACTIVE_BIT   = 16;
  // Widths and sizes
  localparam int DEV_W        = 16;
  localparam int NUM_W        = 24;
  localparam int IDX_W        = 3;
  localparam int TAB_AW       = 4;
  localparam int TAB_WORDS    = 16;
  localparam int SER_BITS     = 16;
  // Reset values and responses
  localparam logic       CAL_RESET   = 1'b1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Modulation modes, in order of {select_hi, select_lo}
  typedef enum logic [1:0] {MODE_PIN, MODE_INDEX, MODE_SERIAL, MODE_FAST} mod_mode_t;
  // Read channel states
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_LOAD, RD_DONE} rd_state_t;
endpackage

// ==== shared/dev_table_if.sv ====
// Carrier between the selector and its deviation table
`timescale 1ns/1ps
`default_nettype none
interface dev_table_if;
  import fsk_dev_pkg::*;
  logic              wrEn;
  logic [TAB_AW-1:0] wrAddr;
  logic [DEV_W-1:0]  wrData;
  logic [1:0]        wrBe;
  logic [TAB_AW-1:0] modAddr;
  logic [DEV_W-1:0]  modData;
  logic [TAB_AW-1:0] busAddr;
  logic [DEV_W-1:0]  busData;
  modport owner (output wrEn, wrAddr, wrData, wrBe, modAddr, busAddr,
                 input modData, busData);
  modport store (input wrEn, wrAddr, wrData, wrBe, modAddr, busAddr,
                 output modData, busData);
endinterface
`default_nettype wire

// ==== design/deviation_store.sv ====
// Two banks of eight deviation words with registered read ports
`timescale 1ns/1ps
`default_nettype none
module deviation_store
  import fsk_dev_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Table access
  dev_table_if.store tbl
);
  typedef struct packed {
    logic [TAB_WORDS-1:0][DEV_W-1:0] words;
    logic [DEV_W-1:0]                modData;
    logic [DEV_W-1:0]                busData;
  } store_t;
  store_t s_r;
  store_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (tbl.wrEn) begin
      if (tbl.wrBe[0]) begin
        s_nxt.words[tbl.wrAddr][7:0] = tbl.wrData[7:0];
      end
      if (tbl.wrBe[1]) begin
        s_nxt.words[tbl.wrAddr][15:8] = tbl.wrData[15:8];
      end
    end
    s_nxt.modData = s_r.words[tbl.modAddr];
    s_nxt.busData = s_r.words[tbl.busAddr];
    if (!reset_n) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  assign tbl.modData = s_r.modData;
  assign tbl.busData = s_r.busData;
endmodule
`default_nettype wire

// ==== design/serial_step_rx.sv ====
// Serial step word receiver on the link clock
`timescale 1ns/1ps
`default_nettype none
module serial_step_rx
  import fsk_dev_pkg::*;
(
  // Link side
  input  wire logic             linkClk,
  input  wire logic             reset_n,
  input  wire logic             symbolDataPin,
  input  wire logic             wordStart,
  // Word handed to the system domain
  output logic [DEV_W-1:0]      word,
  output logic                  wordToggle
);
  typedef struct packed {
    logic             rstMeta;
    logic             rstSync;
    logic             active;
    logic [3:0]       count;
    logic [DEV_W-1:0] shift;
    logic [DEV_W-1:0] word;
    logic             toggle;
  } rx_t;
  rx_t s_r;
  rx_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rstMeta = reset_n;
    s_nxt.rstSync = s_r.rstMeta;
    if (wordStart) begin
      s_nxt.shift  = {{(DEV_W-1){1'b0}}, symbolDataPin};
      s_nxt.count  = 4'h1;
      s_nxt.active = 1'b1;
    end else if (s_r.active) begin
      s_nxt.shift = {s_r.shift[DEV_W-2:0], symbolDataPin};
      if (s_r.count == 4'(SER_BITS - 1)) begin
        s_nxt.word   = {s_r.shift[DEV_W-2:0], symbolDataPin};
        s_nxt.toggle = ~s_r.toggle;
        s_nxt.active = 1'b0;
        s_nxt.count  = 4'h0;
      end else begin
        s_nxt.count = s_r.count + 4'h1;
      end
    end
    if (!s_r.rstSync) begin
      s_nxt.active = 1'b0;
      s_nxt.count  = 4'h0;
      s_nxt.shift  = '0;
      s_nxt.word   = '0;
      s_nxt.toggle = 1'b0;
    end
  end

  always_ff @(posedge linkClk) begin
    s_r <= s_nxt;
  end

  assign word       = s_r.word;
  assign wordToggle = s_r.toggle;
endmodule
`default_nettype wire

// ==== design/fsk_deviation_select.sv ====
// FSK deviation selector with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module fsk_deviation_select
  import fsk_dev_pkg::*;
(
  // System clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // AXI4-Lite write channels
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Symbol pins and serial link
  input  wire logic [IDX_W-1:0]  symbolPins,
  input  wire logic              linkClk,
  input  wire logic              symbolDataPin,
  input  wire logic              wordStart,
  // Synthesizer side
  output logic [NUM_W-1:0]       fracNumerator,
  output logic [DEV_W-1:0]       deviationNow,
  output logic                   modActive,
  output logic                   calStart
);
  typedef struct packed {
    logic [IDX_W-1:0] symMeta;
    logic [IDX_W-1:0] symSync;
    logic             togMeta;
    logic             togSync;
    logic             togSeen;
    logic [DEV_W-1:0] serialWord;
    logic             calEnable;
    logic             setSel;
    logic             modeLo;
    logic             modeHi;
    logic [2:0]       level;
    logic             en1;
    logic             en2;
    logic [IDX_W-1:0] devIndex;
    logic [DEV_W-1:0] direct;
    logic [NUM_W-1:0] baseNum;
    logic             awHave;
    logic [7:0]       awAddr;
    logic             wHave;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    rd_state_t        rdState;
    logic [7:0]       arAddr;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [DEV_W-1:0] devNow;
    logic [NUM_W-1:0] fracNum;
    logic             modActive;
    logic             calStart;
  } sel_t;
  sel_t s_r;
  sel_t s_nxt;

  dev_table_if tbl ();
  logic [DEV_W-1:0] rxWord;
  logic             rxToggle;

  deviation_store u_store (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tbl     (tbl.store)
  );

  serial_step_rx u_rx (
    .linkClk       (linkClk),
    .reset_n       (reset_n),
    .symbolDataPin (symbolDataPin),
    .wordStart     (wordStart),
    .word          (rxWord),
    .wordToggle    (rxToggle)
  );

  function automatic logic [IDX_W-1:0] levelMask(input logic [2:0] lvl);
    logic [IDX_W-1:0] m;
    m = 3'h7;
    if (lvl < 3'h3) begin
      m = 3'((4'h1 << lvl) - 4'h1);
    end
    return m;
  endfunction

  function automatic logic [NUM_W-1:0] sext(input logic [DEV_W-1:0] d);
    return {{(NUM_W-DEV_W){d[DEV_W-1]}}, d};
  endfunction

  function automatic logic isTable(input logic [7:0] a);
    return a >= ADDR_TABLE && a <= ADDR_TABLE_END && a[1:0] == 2'h0;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return isTable(a) || a == ADDR_CTRL || a == ADDR_MODE || a == ADDR_DEVSEL ||
           a == ADDR_DIRECT || a == ADDR_NUMBASE || a == ADDR_STATUS;
  endfunction

  function automatic logic [31:0] readWord(input logic [7:0] a, input sel_t s);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      ADDR_CTRL: begin
        v[CAL_BIT] = s.calEnable;
        v[SET_BIT] = s.setSel;
      end
      ADDR_MODE: begin
        v[MODE_LO_BIT] = s.modeLo;
        v[MODE_HI_BIT] = s.modeHi;
        v[LVL_LSB+:3]  = s.level;
        v[EN1_BIT]     = s.en1;
        v[EN2_BIT]     = s.en2;
      end
      ADDR_DEVSEL:  v[IDX_W-1:0] = s.devIndex;
      ADDR_DIRECT:  v[DEV_W-1:0] = s.direct;
      ADDR_NUMBASE: v[NUM_W-1:0] = s.baseNum;
      ADDR_STATUS: begin
        v[DEV_W-1:0]  = s.devNow;
        v[ACTIVE_BIT] = s.modActive;
      end
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i+:8] = n[8*i+:8];
      end
    end
    return r;
  endfunction

  mod_mode_t        mode;
  logic             setEn;
  logic             usesTable;
  logic [IDX_W-1:0] lvlMask;
  logic [IDX_W-1:0] index;
  logic             wrExec;
  logic [31:0]      wrWord;

  always_comb begin
    mode      = mod_mode_t'({s_r.modeHi, s_r.modeLo});
    setEn     = s_r.setSel ? s_r.en2 : s_r.en1;
    usesTable = mode == MODE_PIN || mode == MODE_INDEX;
    lvlMask   = levelMask(s_r.level);
    index     = (mode == MODE_PIN) ? s_r.symSync : s_r.devIndex;
    index     = index & lvlMask;
    wrExec    = s_r.awHave && s_r.wHave && !s_r.bvalid;
    wrWord    = merge(readWord(s_r.awAddr, s_r), s_r.wData, s_r.wStrb);
    tbl.modAddr = {s_r.setSel, index};
    tbl.busAddr = s_r.arAddr[5:2];
    tbl.wrEn    = wrExec && isTable(s_r.awAddr);
    tbl.wrAddr  = s_r.awAddr[5:2];
    tbl.wrData  = s_r.wData[DEV_W-1:0];
    tbl.wrBe    = s_r.wStrb[1:0];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.calStart = 1'b0;
    // Pin and link synchronisers
    s_nxt.symMeta = symbolPins;
    s_nxt.symSync = s_r.symMeta;
    s_nxt.togMeta = rxToggle;
    s_nxt.togSync = s_r.togMeta;
    s_nxt.togSeen = s_r.togSync;
    if (s_r.togSync != s_r.togSeen) begin
      s_nxt.serialWord = rxWord;
    end
    // Write address and data, either order
    if (awvalid && s_r.awready) begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (wrExec) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = isMapped(s_r.awAddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_r.awAddr)
        ADDR_CTRL: begin
          s_nxt.calEnable = wrWord[CAL_BIT];
          s_nxt.setSel    = wrWord[SET_BIT];
          s_nxt.calStart  = wrWord[CAL_BIT];
        end
        ADDR_MODE: begin
          s_nxt.modeLo = wrWord[MODE_LO_BIT];
          s_nxt.modeHi = wrWord[MODE_HI_BIT];
          s_nxt.level  = wrWord[LVL_LSB+:3];
          s_nxt.en1    = wrWord[EN1_BIT];
          s_nxt.en2    = wrWord[EN2_BIT];
        end
        ADDR_DEVSEL:  s_nxt.devIndex = wrWord[IDX_W-1:0];
        ADDR_DIRECT:  s_nxt.direct = wrWord[DEV_W-1:0];
        ADDR_NUMBASE: s_nxt.baseNum = wrWord[NUM_W-1:0];
        default: ;
      endcase
    end else if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.awHave && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.wHave && !s_nxt.bvalid;
    // Read channel
    case (s_r.rdState)
      RD_IDLE: begin
        s_nxt.arready = 1'b1;
        if (arvalid && s_r.arready) begin
          s_nxt.arAddr  = araddr;
          s_nxt.arready = 1'b0;
          s_nxt.rdState = RD_FETCH;
        end
      end
      RD_FETCH: s_nxt.rdState = RD_LOAD;
      RD_LOAD: begin
        s_nxt.rvalid  = 1'b1;
        s_nxt.rresp   = isMapped(s_r.arAddr) ? RESP_OKAY : RESP_SLVERR;
        s_nxt.rdata   = isTable(s_r.arAddr) ? {16'h0, tbl.busData}
                                            : readWord(s_r.arAddr, s_r);
        s_nxt.rdState = RD_DONE;
      end
      RD_DONE: begin
        if (rready) begin
          s_nxt.rvalid  = 1'b0;
          s_nxt.arready = 1'b1;
          s_nxt.rdState = RD_IDLE;
        end
      end
      default: s_nxt.rdState = RD_IDLE;
    endcase
    // Deviation source per mode
    s_nxt.modActive = setEn;
    case (mode)
      MODE_PIN, MODE_INDEX: s_nxt.devNow = tbl.modData;
      MODE_SERIAL: s_nxt.devNow = s_r.serialWord;
      MODE_FAST: s_nxt.devNow = s_r.direct;
      default: s_nxt.devNow = '0;
    endcase
    if (!setEn) begin
      s_nxt.devNow = '0;
    end
    s_nxt.fracNum = s_r.baseNum + sext(s_r.devNow);
    if (!reset_n) begin
      s_nxt = '0;
      s_nxt.calEnable = CAL_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  assign awready       = s_r.awready;
  assign wready        = s_r.wready;
  assign bvalid        = s_r.bvalid;
  assign bresp         = s_r.bresp;
  assign arready       = s_r.arready;
  assign rvalid        = s_r.rvalid;
  assign rdata         = s_r.rdata;
  assign rresp         = s_r.rresp;
  assign fracNumerator = s_r.fracNum;
  assign deviationNow  = s_r.devNow;
  assign modActive     = s_r.modActive;
  assign calStart      = s_r.calStart;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_cal_start;
    wrExec && s_r.awAddr == ADDR_CTRL && wrWord[CAL_BIT] |=> calStart ##1 !calStart;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_cal_quiet;
    calStart |-> $past(wrExec) && s_r.calEnable;
  endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("calibration started unasked");

  property p_frac_step;
    $stable(s_r.baseNum) |=> fracNumerator == $past(s_r.baseNum) + sext($past(deviationNow));
  endproperty
  a_frac_step: assert property (p_frac_step) else $error("numerator not base plus steps");

  property p_pin_lookup;
    mode == MODE_PIN |-> tbl.modAddr[2:0] == (s_r.symSync & lvlMask);
  endproperty
  a_pin_lookup: assert property (p_pin_lookup) else $error("pin symbol not applied");

  property p_index_apply;
    wrExec && s_r.awAddr == ADDR_DEVSEL && mode == MODE_INDEX
      |=> tbl.modAddr[2:0] == ($past(wrWord[2:0]) & lvlMask);
  endproperty
  a_index_apply: assert property (p_index_apply) else $error("index not applied");

  property p_level_cap;
    usesTable |-> (tbl.modAddr[2:0] & ~lvlMask) == 3'h0;
  endproperty
  a_level_cap: assert property (p_level_cap) else $error("index beyond level count");

  property p_fast_apply;
    mode == MODE_FAST && setEn |=> deviationNow == $past(s_r.direct);
  endproperty
  a_fast_apply: assert property (p_fast_apply) else $error("fast word not applied");

  property p_serial_apply;
    mode == MODE_SERIAL && setEn |=> deviationNow == $past(s_r.serialWord);
  endproperty
  a_serial_apply: assert property (p_serial_apply) else $error("serial word not applied");

  property p_bank_sel;
    usesTable |-> tbl.modAddr[3] == s_r.setSel;
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("wrong bank selected");
endmodule
`default_nettype wire

// ==== sim/baseband_model.sv ====
// Baseband controller model: symbol pins and serial step words
`timescale 1ns/1ps
`default_nettype none
module baseband_model
  import fsk_dev_pkg::*;
(
  // System clock
  input  wire logic         clk_sys,
  // Symbol pins and serial link
  output logic [IDX_W-1:0]  symbolPins,
  output logic              linkClk,
  output logic              symbolDataPin,
  output logic              wordStart
);
  logic run;

  // Link clock, free-running until pause(), then stopped low outside frames
  initial begin
    run = 1'b1;
    linkClk = 1'b0;
    symbolPins = '0;
    symbolDataPin = 1'b0;
    wordStart = 1'b0;
    #3;
    forever begin
      #80;
      linkClk = run ? ~linkClk : 1'b0;
    end
  end

  // Negative step as 16-bit two's complement
  function automatic logic [DEV_W-1:0] negStep(input logic [DEV_W-1:0] s);
    return ~s + 16'h0001;
  endfunction

  task automatic pause();
    run = 1'b0;
  endtask

  task automatic setSymbol(input logic [IDX_W-1:0] v);
    @(posedge clk_sys);
    symbolPins <= v;
  endtask

  // Word clocked MSB first, line inverted once released
  task automatic sendWord(input logic [DEV_W-1:0] w);
    wordStart = 1'b1;
    symbolDataPin = w[DEV_W-1];
    run = 1'b1;
    for (int i = DEV_W - 2; i >= 0; i--) begin
      @(negedge linkClk);
      wordStart = 1'b0;
      symbolDataPin = w[i];
    end
    @(negedge linkClk);
    symbolDataPin = ~w[0];
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_fsk_deviation_select.sv ====
// Self-checking bench of the FSK deviation selector
`timescale 1ns/1ps
`default_nettype none
module tb_fsk_deviation_select;
  import fsk_dev_pkg::*;
  localparam logic [NUM_W-1:0] BASE = 24'h800000;
  logic              clk_sys, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, modActive, calStart;
  logic              linkClk, symbolDataPin, wordStart;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [IDX_W-1:0]  symbolPins;
  logic [NUM_W-1:0]  fracNumerator;
  logic [DEV_W-1:0]  deviationNow;
  int                fails, checks_done, calCount;

  fsk_deviation_select DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .symbolPins(symbolPins), .linkClk(linkClk), .symbolDataPin(symbolDataPin),
    .wordStart(wordStart), .fracNumerator(fracNumerator), .deviationNow(deviationNow),
    .modActive(modActive), .calStart(calStart)
  );
  baseband_model bb (
    .clk_sys(clk_sys), .symbolPins(symbolPins), .linkClk(linkClk),
    .symbolDataPin(symbolDataPin), .wordStart(wordStart)
  );

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (calStart === 1'b1) calCount <= calCount + 1;

  task automatic end_sim();
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tmo();
    fails++;
    end_sim();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
      if (n > 40) tmo();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Waits a bounded time for the deviation, then checks it and the numerator
  task automatic devIs(input logic [DEV_W-1:0] e);
    int n;
    n = 0;
    while (deviationNow !== e && n < 12) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (2) @(posedge clk_sys);
    chk({16'h0, deviationNow}, {16'h0, e});
    chk({8'h0, fracNumerator}, {8'h0, BASE + {{8{e[15]}}, e}});
  endtask

  // Rounded step counts, precomputed
  // Table word of bank b, index i; indices 2, 3, 6 and 7 hold negative steps
  function automatic logic [DEV_W-1:0] tv(input int b, input int i);
    logic [DEV_W-1:0] s;
    s = DEV_W'(16'h0500 + b * 16'h0100 + i * 16'h0011);
    return (i % 4 > 1) ? bb.negStep(s) : s;
  endfunction

  task automatic scReset();
    rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_MODE, 32'h0, RESP_OKAY);
    chk({31'h0, modActive}, 32'h0);
  endtask

  task automatic scCal();
    int c;
    c = calCount;
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    chk(calCount - c, 32'h1);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    chk(calCount - c, 32'h1);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
  endtask

  task automatic scTable();
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 8; i++)
        wr(8'(ADDR_TABLE + 4 * (b * 8 + i)), {16'h0, tv(b, i)}, RESP_OKAY);
    wr(ADDR_NUMBASE, {8'h0, BASE}, RESP_OKAY);
    rd(8'h4c, {16'h0, tv(0, 3)}, RESP_OKAY);
    rd(8'h6c, {16'h0, tv(1, 3)}, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
  endtask

  task automatic scPin();
    logic [IDX_W-1:0] sym [6] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h7, 3'h6};
    wr(ADDR_MODE, 32'h28, RESP_OKAY);
    foreach (sym[k]) begin
      bb.setSymbol(sym[k]);
      devIs(tv(0, int'(sym[k] & 3'h3)));
    end
    chk({31'h0, modActive}, 32'h1);
    wr(ADDR_MODE, 32'h2c, RESP_OKAY);
    bb.setSymbol(3'h7);
    devIs(tv(0, 7));
  endtask

  task automatic scIndex();
    logic [IDX_W-1:0] ix [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
    wr(ADDR_MODE, 32'h29, RESP_OKAY);
    foreach (ix[k]) begin
      wr(ADDR_DEVSEL, {29'h0, ix[k]}, RESP_OKAY);
      devIs(tv(0, int'(ix[k])));
    end
  endtask

  task automatic scFast();
    wr(ADDR_MODE, 32'h23, RESP_OKAY);
    wr(ADDR_DIRECT, 32'h206, RESP_OKAY);
    devIs(16'h0206);
    wr(ADDR_DIRECT, 32'hfab2, RESP_OKAY);
    devIs(16'hfab2);
    wr(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h1fab2, RESP_OKAY);
  endtask

  task automatic scSerial();
    wr(ADDR_MODE, 32'h22, RESP_OKAY);
    bb.sendWord(16'h054d);
    devIs(16'h054d);
    bb.sendWord(bb.negStep(16'h068e));
    devIs(16'hf972);
  endtask

  task automatic scSet();
    wr(ADDR_CTRL, 32'h40, RESP_OKAY);
    wr(ADDR_MODE, 32'h4c, RESP_OKAY);
    bb.setSymbol(3'h5);
    devIs(tv(1, 5));
    wr(ADDR_MODE, 32'h2c, RESP_OKAY);
    devIs(16'h0);
    chk({31'h0, modActive}, 32'h0);
  endtask

  initial begin
    reset_n = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    bb.pause();
    scReset();
    scCal();
    scTable();
    scPin();
    scIndex();
    scFast();
    scSerial();
    scSet();
    end_sim();
  end
endmodule
`default_nettype wire
